// ---- shared/ierr_pkg.sv ----
// Package: register map, field positions and helpers of internal error regs
package ierr_pkg;

    // Register bus geometry
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned ADDR_W      = 12;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL    = 12'h480;
    localparam logic [11:0] OFS_STS     = 12'h484;
    localparam logic [11:0] OFS_MSK     = 12'h488;
    localparam logic [11:0] OFS_IRQ_STS = 12'h490;
    localparam logic [11:0] OFS_IRQ_MSK = 12'h494;

    // Reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
    localparam logic [31:0] STS_RST     = 32'h0000_0000;
    localparam logic [31:0] MSK_RST     = 32'h0000_0000;
    localparam logic [31:0] IRQ_STS_RST = 32'h0000_0000;
    localparam logic [31:0] IRQ_MSK_RST = 32'h0000_0000;

    // Control fields
    localparam int unsigned CTRL_EN_BIT = 0;

    // Status and mask field positions (same layout in both)
    localparam int unsigned STS_IN_PTO  = 0;
    localparam int unsigned STS_IN_NPTO = 1;
    localparam int unsigned STS_IN_CTO  = 2;
    localparam int unsigned STS_EG_PTO  = 4;
    localparam int unsigned STS_EG_NPTO = 5;
    localparam int unsigned STS_EG_CTO  = 6;
    localparam int unsigned STS_ID_SBE  = 7;
    localparam int unsigned STS_ID_DBE  = 8;
    localparam int unsigned STS_IC_SBE  = 9;
    localparam int unsigned STS_IC_DBE  = 10;
    localparam int unsigned STS_ED_SBE  = 11;
    localparam int unsigned STS_ED_DBE  = 12;
    localparam int unsigned STS_EC_SBE  = 13;
    localparam int unsigned STS_EC_DBE  = 14;
    localparam int unsigned STS_E2E_PE  = 15;
    localparam int unsigned STS_LINK    = 16;
    localparam int unsigned STS_RC_SBE  = 17;
    localparam int unsigned STS_RC_DBE  = 18;
    localparam int unsigned NUM_SRC     = 19;

    // Implemented status bits; bit 3 and 31:19 read as zero
    localparam logic [31:0] STS_IMPL    = 32'h0007_FFF7;
    // Double-bit ECC error positions
    localparam logic [31:0] STS_DBE     = 32'h0004_5500;

    // Interrupt status fields
    localparam int unsigned IRQ_REPORT  = 0;
    localparam int unsigned IRQ_DOUBLE  = 1;
    localparam int unsigned IRQ_LINK    = 2;
    localparam logic [31:0] IRQ_IMPL    = 32'h0000_0007;

    // Sticky flag update where a set beats a clear in the same cycle
    function automatic logic [31:0] sticky(input logic [31:0] old,
                                           input logic [31:0] set,
                                           input logic [31:0] clr);
        sticky = (old & ~clr) | set;
    endfunction : sticky

    // Address decode of one register strobe
    function automatic logic hit(input logic        strobe,
                                 input logic [11:0] addr,
                                 input logic [11:0] ofs);
        hit = strobe && (addr == ofs);
    endfunction : hit

endpackage : ierr_pkg

// ---- core/ierr_src_capture.sv ----
// Error source capture: pulse sources plus rising edge of a level flag
module ierr_src_capture #(
    parameter int unsigned N        = 19,
    parameter int unsigned LINK_BIT = 16
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst_n,
    input  wire logic [N-1:0] i_evt,
    input  wire logic         i_link_flag,
    output logic      [N-1:0] o_set
);

    // Refuse a link position outside the vector
    if (LINK_BIT >= N) begin : g_bad_link_bit
        $error("ierr_src_capture: LINK_BIT must be below N");
    end

    logic link_ff;

    // Previous level of the link flag
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_ff <= 1'b0;
        end else begin
            link_ff <= i_link_flag;
        end
    end

    // Pulses pass straight; the flag counts only when it becomes set
    always_comb begin
        o_set           = i_evt;
        o_set[LINK_BIT] = i_evt[LINK_BIT] | (i_link_flag & ~link_ff);
    end

endmodule : ierr_src_capture

// ---- core/ierr_regs.sv ----
// Internal error report registers: capture, mask, report and interrupt
//
// Notes on behaviour
// - Control enable bit, reset to one, gates forwarding of internal errors.
// - Ingress posted, non-posted, completion time-outs set status bits 0-2.
// - Egress posted, non-posted, completion time-outs set status bits 4-6.
// - Ingress data RAM single-bit sets bit 7, double-bit sets bit 8.
// - Ingress control RAM single-bit sets bit 9, double-bit sets bit 10.
// - Egress data RAM single-bit sets bit 11, double-bit sets bit 12.
// - Egress control RAM single-bit sets bit 13, double-bit sets bit 14.
// - End-to-end parity error sets bit 15, cleared by writing one.
// - Unreliable link flag becoming set sets bit 16, write one clears.
// - Replay control RAM single-bit sets bit 17, double-bit bit 18.
// - Mask bit stops its flag reporting but never stops its recording.
module ierr_regs #(
    parameter int unsigned ADDR_W = ierr_pkg::ADDR_W
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    // Ingress frame buffer events
    input  wire logic              i_ingress_posted_timeout,
    input  wire logic              i_ingress_nonposted_timeout,
    input  wire logic              i_ingress_completion_timeout,
    input  wire logic              i_ingress_data_single_ecc,
    input  wire logic              i_ingress_data_double_ecc,
    input  wire logic              i_ingress_ctrl_single_ecc,
    input  wire logic              i_ingress_ctrl_double_ecc,
    // Egress frame buffer events
    input  wire logic              i_egress_posted_timeout,
    input  wire logic              i_egress_nonposted_timeout,
    input  wire logic              i_egress_completion_timeout,
    input  wire logic              i_egress_data_single_ecc,
    input  wire logic              i_egress_data_double_ecc,
    input  wire logic              i_egress_ctrl_single_ecc,
    input  wire logic              i_egress_ctrl_double_ecc,
    // Other sources
    input  wire logic              i_end_to_end_parity_error,
    input  wire logic              i_unreliable_link_flag,
    input  wire logic              i_replay_ctrl_single_ecc,
    input  wire logic              i_replay_ctrl_double_ecc,
    // Report pulse and interrupt
    output logic                   o_int_err_event,
    output logic                   o_irq
);

    // Decode compares the low twelve address bits
    if (ADDR_W < 12) begin : g_bad_addr_w
        $error("ierr_regs: ADDR_W must be at least 12");
    end

    localparam int unsigned N = ierr_pkg::NUM_SRC;

    logic [N-1:0] evt;
    logic [N-1:0] src_set;
    logic [31:0]  set32;
    logic [31:0]  newly;
    logic [11:0]  addr;
    logic         wr_ctrl;
    logic         wr_sts;
    logic         wr_msk;
    logic         wr_imsk;
    logic         rd_ists;
    logic [31:0]  sts_clr;
    logic [31:0]  irq_set;
    logic [31:0]  irq_clr;
    logic [31:0]  rd_mux;

    logic         ctrl_en_ff;
    logic [31:0]  sts_ff;
    logic [31:0]  msk_ff;
    logic [31:0]  irq_sts_ff;
    logic [31:0]  irq_msk_ff;
    logic [31:0]  rdata_ff;
    logic         event_ff;

    logic         nxt_event;
    logic [31:0]  nxt_sts;
    logic [31:0]  nxt_irq_sts;

    // Gather pulse sources into the status layout
    always_comb begin
        evt                          = '0;
        evt[ierr_pkg::STS_IN_PTO]    = i_ingress_posted_timeout;
        evt[ierr_pkg::STS_IN_NPTO]   = i_ingress_nonposted_timeout;
        evt[ierr_pkg::STS_IN_CTO]    = i_ingress_completion_timeout;
        evt[ierr_pkg::STS_EG_PTO]    = i_egress_posted_timeout;
        evt[ierr_pkg::STS_EG_NPTO]   = i_egress_nonposted_timeout;
        evt[ierr_pkg::STS_EG_CTO]    = i_egress_completion_timeout;
        evt[ierr_pkg::STS_ID_SBE]    = i_ingress_data_single_ecc;
        evt[ierr_pkg::STS_ID_DBE]    = i_ingress_data_double_ecc;
        evt[ierr_pkg::STS_IC_SBE]    = i_ingress_ctrl_single_ecc;
        evt[ierr_pkg::STS_IC_DBE]    = i_ingress_ctrl_double_ecc;
        evt[ierr_pkg::STS_ED_SBE]    = i_egress_data_single_ecc;
        evt[ierr_pkg::STS_ED_DBE]    = i_egress_data_double_ecc;
        evt[ierr_pkg::STS_EC_SBE]    = i_egress_ctrl_single_ecc;
        evt[ierr_pkg::STS_EC_DBE]    = i_egress_ctrl_double_ecc;
        evt[ierr_pkg::STS_E2E_PE]    = i_end_to_end_parity_error;
        evt[ierr_pkg::STS_RC_SBE]    = i_replay_ctrl_single_ecc;
        evt[ierr_pkg::STS_RC_DBE]    = i_replay_ctrl_double_ecc;
    end

    // Link flag edge joins the pulse sources
    ierr_src_capture #(
        .N        (N),
        .LINK_BIT (ierr_pkg::STS_LINK)
    ) u_capture (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_evt       (evt),
        .i_link_flag (i_unreliable_link_flag),
        .o_set       (src_set)
    );

    // Register strobe decode
    assign addr    = i_addr[11:0];
    assign wr_ctrl = ierr_pkg::hit(i_wr, addr, ierr_pkg::OFS_CTRL);
    assign wr_sts  = ierr_pkg::hit(i_wr, addr, ierr_pkg::OFS_STS);
    assign wr_msk  = ierr_pkg::hit(i_wr, addr, ierr_pkg::OFS_MSK);
    assign wr_imsk = ierr_pkg::hit(i_wr, addr, ierr_pkg::OFS_IRQ_MSK);
    assign rd_ists = ierr_pkg::hit(i_rd, addr, ierr_pkg::OFS_IRQ_STS);

    // Status update: hardware set beats a write-one clear
    assign set32   = {{(32 - N){1'b0}}, src_set} & ierr_pkg::STS_IMPL;
    assign sts_clr = wr_sts ? i_wdata : 32'h0000_0000;
    assign nxt_sts = ierr_pkg::sticky(sts_ff, set32, sts_clr)
                     & ierr_pkg::STS_IMPL;

    // Flags set this cycle that were clear and are not masked
    assign newly     = set32 & ~sts_ff & ~msk_ff;
    assign nxt_event = ctrl_en_ff && (newly != 32'h0000_0000);

    // Control register, enable out of reset
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_en_ff <= ierr_pkg::CTRL_RST[ierr_pkg::CTRL_EN_BIT];
        end else if (wr_ctrl) begin
            ctrl_en_ff <= i_wdata[ierr_pkg::CTRL_EN_BIT];
        end
    end

    // Sticky status flags
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sts_ff <= ierr_pkg::STS_RST;
        end else begin
            sts_ff <= nxt_sts;
        end
    end

    // Report mask, same layout as the status
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            msk_ff <= ierr_pkg::MSK_RST;
        end else if (wr_msk) begin
            msk_ff <= i_wdata & ierr_pkg::STS_IMPL;
        end
    end

    // One-cycle report pulse to the error reporting logic
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            event_ff <= 1'b0;
        end else begin
            event_ff <= nxt_event;
        end
    end

    assign o_int_err_event = event_ff;

    // Interrupt events: report issued, double-bit error, link unreliable
    always_comb begin
        irq_set                       = '0;
        irq_set[ierr_pkg::IRQ_REPORT] = nxt_event;
        irq_set[ierr_pkg::IRQ_DOUBLE] =
            (set32 & ierr_pkg::STS_DBE) != 32'h0000_0000;
        irq_set[ierr_pkg::IRQ_LINK]   = set32[ierr_pkg::STS_LINK];
    end

    // A read of the interrupt status clears it; a new event still wins
    assign irq_clr     = rd_ists ? 32'hFFFF_FFFF : 32'h0000_0000;
    assign nxt_irq_sts = ierr_pkg::sticky(irq_sts_ff, irq_set, irq_clr)
                         & ierr_pkg::IRQ_IMPL;

    // Interrupt status
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_sts_ff <= ierr_pkg::IRQ_STS_RST;
        end else begin
            irq_sts_ff <= nxt_irq_sts;
        end
    end

    // Interrupt mask, one enables the matching status bit
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_msk_ff <= ierr_pkg::IRQ_MSK_RST;
        end else if (wr_imsk) begin
            irq_msk_ff <= i_wdata & ierr_pkg::IRQ_IMPL;
        end
    end

    // Level interrupt while any enabled status bit is set
    assign o_irq = (irq_sts_ff & irq_msk_ff) != 32'h0000_0000;

    // Read mux, unmapped offsets read zero
    always_comb begin
        unique case (addr)
            ierr_pkg::OFS_CTRL:    rd_mux = {31'h0000_0000, ctrl_en_ff};
            ierr_pkg::OFS_STS:     rd_mux = sts_ff;
            ierr_pkg::OFS_MSK:     rd_mux = msk_ff;
            ierr_pkg::OFS_IRQ_STS: rd_mux = irq_sts_ff;
            ierr_pkg::OFS_IRQ_MSK: rd_mux = irq_msk_ff;
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= i_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_ff;

    // Checks on the reporting and recording behaviour

    // No report while the enable is clear
    property p_en_gate;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !ctrl_en_ff |=> !o_int_err_event;
    endproperty
    a_en_gate: assert property (p_en_gate)
        else $error("report raised while enable clear");

    // Ingress time-outs recorded
    property p_in_to;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (src_set[2:0] != 3'h0) |=>
            ((sts_ff[2:0] & $past(src_set[2:0])) == $past(src_set[2:0]));
    endproperty
    a_in_to: assert property (p_in_to)
        else $error("ingress time-out not recorded");

    // Egress time-outs recorded
    property p_eg_to;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (src_set[6:4] != 3'h0) |=>
            ((sts_ff[6:4] & $past(src_set[6:4])) == $past(src_set[6:4]));
    endproperty
    a_eg_to: assert property (p_eg_to)
        else $error("egress time-out not recorded");

    // Ingress data RAM ECC recorded
    property p_in_dat;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_ingress_data_single_ecc ##0 i_ingress_data_double_ecc
            |=> sts_ff[8:7] == 2'h3;
    endproperty
    a_in_dat: assert property (p_in_dat)
        else $error("ingress data ECC not recorded");

    // Ingress control RAM ECC recorded
    property p_in_ctl;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_ingress_ctrl_double_ecc |=> sts_ff[10]
            ##1 (sts_ff[10] || $past(wr_sts && i_wdata[10]));
    endproperty
    a_in_ctl: assert property (p_in_ctl)
        else $error("ingress control ECC flag lost");

    // Egress data RAM ECC recorded
    property p_eg_dat;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_egress_data_single_ecc || i_egress_data_double_ecc) |=>
            sts_ff[11] == $past(i_egress_data_single_ecc
                                | (sts_ff[11] & !(wr_sts & i_wdata[11])));
    endproperty
    a_eg_dat: assert property (p_eg_dat)
        else $error("egress data ECC flag wrong");

    // Egress control RAM ECC recorded
    property p_eg_ctl;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_egress_ctrl_single_ecc |=> sts_ff[13];
    endproperty
    a_eg_ctl: assert property (p_eg_ctl)
        else $error("egress control ECC not recorded");

    // Parity flag clears on a one written with no new error
    property p_e2e_clr;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (wr_sts && i_wdata[15] && !src_set[15]) |=> !sts_ff[15];
    endproperty
    a_e2e_clr: assert property (p_e2e_clr)
        else $error("parity flag not cleared by write one");

    // Link flag rising sets its status even under a clear
    property p_link;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_unreliable_link_flag && !$past(i_unreliable_link_flag))
            |=> sts_ff[16];
    endproperty
    a_link: assert property (p_link)
        else $error("unreliable link not recorded");

    // Replay control RAM ECC recorded
    property p_replay;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_replay_ctrl_double_ecc |=> sts_ff[18];
    endproperty
    a_replay: assert property (p_replay)
        else $error("replay double-bit error not recorded");

    // Masked sources record but do not report
    property p_mask;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ((set32 & msk_ff) != 32'h0000_0000 && newly == 32'h0000_0000)
            |=> !o_int_err_event
                && ((sts_ff & $past(set32)) == $past(set32));
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask changed recording or reported");

    // A new unmasked flag with enable set reports in the next cycle
    property p_report;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (ctrl_en_ff && newly != 32'h0000_0000) |=> o_int_err_event;
    endproperty
    a_report: assert property (p_report)
        else $error("internal error report missing");

endmodule : ierr_regs

// ---- tb/ierr_regs_tb.sv ----
// Self-checking testbench of the internal error report registers
module ierr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // One note per driven cycle: read flag, read data, event, interrupt
    typedef struct packed {
        logic        rd;
        logic [31:0] data;
        logic        evt;
        logic        irq;
    } ierr_note_s;

    logic        i_sys_clk;
    logic        i_rst_n;
    logic [11:0] i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic        o_int_err_event;
    logic        o_irq;
    logic [18:0] src;
    logic        link;
    ierr_note_s  q_note[$];
    int          n_errors;
    int          n_tests;
    int          n_cyc;
    logic [31:0] m_ctl;
    logic [31:0] m_sts;
    logic [31:0] m_msk;
    logic [31:0] m_ists;
    logic [31:0] m_imsk;
    logic        m_link;
    logic [11:0] ofs[7] = '{12'h480, 12'h484, 12'h488, 12'h490, 12'h494,
                            12'h48C, 12'h000};

    // Clock at 200 MHz
    initial i_sys_clk = 1'b0;
    always #2.5 i_sys_clk = ~i_sys_clk;

    ierr_regs i_dut (
        .i_sys_clk                    (i_sys_clk),
        .i_rst_n                      (i_rst_n),
        .i_addr                       (i_addr),
        .i_wdata                      (i_wdata),
        .i_wr                         (i_wr),
        .i_rd                         (i_rd),
        .o_rdata                      (o_rdata),
        .i_ingress_posted_timeout     (src[0]),
        .i_ingress_nonposted_timeout  (src[1]),
        .i_ingress_completion_timeout (src[2]),
        .i_ingress_data_single_ecc    (src[7]),
        .i_ingress_data_double_ecc    (src[8]),
        .i_ingress_ctrl_single_ecc    (src[9]),
        .i_ingress_ctrl_double_ecc    (src[10]),
        .i_egress_posted_timeout      (src[4]),
        .i_egress_nonposted_timeout   (src[5]),
        .i_egress_completion_timeout  (src[6]),
        .i_egress_data_single_ecc     (src[11]),
        .i_egress_data_double_ecc     (src[12]),
        .i_egress_ctrl_single_ecc     (src[13]),
        .i_egress_ctrl_double_ecc     (src[14]),
        .i_end_to_end_parity_error    (src[15]),
        .i_unreliable_link_flag       (link),
        .i_replay_ctrl_single_ecc     (src[17]),
        .i_replay_ctrl_double_ecc     (src[18]),
        .o_int_err_event              (o_int_err_event),
        .o_irq                        (o_irq)
    );

    // Comparisons of a data word and of a single flag
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    // One bus and source cycle; the reference model notes the outcome
    task automatic cyc(input logic w, input logic r, input logic [11:0] a,
                       input logic [31:0] d, input logic [18:0] s,
                       input logic lk);
        ierr_note_s  n;
        logic [31:0] set;
        logic [31:0] clr;
        logic        rise;
        @(posedge i_sys_clk);
        i_wr    <= w;
        i_rd    <= r;
        i_addr  <= a;
        i_wdata <= d;
        src     <= s;
        link    <= lk;
        rise = lk & ~m_link;
        m_link = lk;
        set = ({13'h0, s} & ierr_pkg::STS_IMPL & ~32'h0001_0000)
              | {15'h0, rise, 16'h0};
        n.rd   = r;
        n.data = 32'h0;
        if (r) begin
            case (a)
                ierr_pkg::OFS_CTRL:    n.data = m_ctl;
                ierr_pkg::OFS_STS:     n.data = m_sts;
                ierr_pkg::OFS_MSK:     n.data = m_msk;
                ierr_pkg::OFS_IRQ_STS: n.data = m_ists;
                ierr_pkg::OFS_IRQ_MSK: n.data = m_imsk;
                default:               n.data = 32'h0;
            endcase
        end
        n.evt = m_ctl[0] & (|(set & ~m_sts & ~m_msk));
        clr = (w && a == ierr_pkg::OFS_STS) ? d : 32'h0;
        m_sts = (m_sts & ~clr) | set;
        if (r && a == ierr_pkg::OFS_IRQ_STS) begin
            m_ists = 32'h0;
        end
        m_ists = m_ists | {29'h0, rise, |(set & ierr_pkg::STS_DBE), n.evt};
        if (w) begin
            case (a)
                ierr_pkg::OFS_CTRL:    m_ctl = {31'h0, d[0]};
                ierr_pkg::OFS_MSK:     m_msk = d & ierr_pkg::STS_IMPL;
                ierr_pkg::OFS_IRQ_MSK: m_imsk = d & ierr_pkg::IRQ_IMPL;
                default:               m_ctl = m_ctl;
            endcase
        end
        n.irq = |(m_ists & m_imsk);
        q_note.push_back(n);
    endtask : cyc

    // Bus shorthands
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        cyc(1'b1, 1'b0, a, d, 19'h0, m_link);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        cyc(1'b0, 1'b1, a, 32'h0, 19'h0, m_link);
    endtask : rd

    // Raise the sources of m, with a status clear of m alongside if w
    task automatic fire(input logic [31:0] m, input logic w);
        cyc(w, 1'b0, ierr_pkg::OFS_STS, m, m[18:0] & ~19'h1_0000, m[16]);
        cyc(1'b0, 1'b0, 12'h0, 32'h0, 19'h0, 1'b0);
    endtask : fire

    // Monitor: each settled cycle takes the oldest note and compares
    always @(posedge i_sys_clk) begin : mon
        ierr_note_s n;
        #1;
        if (q_note.size() > 1) begin
            n = q_note.pop_front();
            cmp_data(o_rdata, n.data);
            cmp_bit(o_int_err_event, n.evt);
            cmp_bit(o_irq, n.irq);
        end
    end

    // Hang guard
    always @(posedge i_sys_clk) begin
        n_cyc++;
        if (n_cyc == 3000) begin
            n_errors++;
            complete_run();
        end
    end

    // Counts and verdict
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin : main
        logic [31:0] m;
        logic [31:0] r;
        logic [31:0] s;
        logic [31:0] d;
        i_rst_n  = 1'b0;
        i_addr   = 12'h0;
        i_wdata  = 32'h0;
        i_wr     = 1'b0;
        i_rd     = 1'b0;
        src      = 19'h0;
        link     = 1'b0;
        n_errors = 0;
        n_tests  = 0;
        n_cyc    = 0;
        m_ctl    = ierr_pkg::CTRL_RST;
        m_sts    = ierr_pkg::STS_RST;
        m_msk    = ierr_pkg::MSK_RST;
        m_ists   = ierr_pkg::IRQ_STS_RST;
        m_imsk   = ierr_pkg::IRQ_MSK_RST;
        m_link   = 1'b0;
        void'($urandom(3348));
        repeat (16) @(posedge i_sys_clk);
        cmp_data(o_rdata, 32'h0);
        cmp_bit(o_int_err_event, 1'b0);
        i_rst_n <= 1'b1;
        // Reset values, then reserved bits and two unmapped places
        foreach (ofs[i]) rd(ofs[i]);
        foreach (ofs[i]) wr(ofs[i], 32'hFFFF_FFFF);
        foreach (ofs[i]) rd(ofs[i]);
        // Each source alone: masked, unmasked, repeated, clear collision
        for (int b = 0; b < 19; b++) begin
            if (b != 3) begin
                m = 32'h1 << b;
                wr(ierr_pkg::OFS_MSK, m);
                fire(m, 1'b0);
                rd(ierr_pkg::OFS_STS);
                wr(ierr_pkg::OFS_STS, m);
                wr(ierr_pkg::OFS_MSK, ~m);
                fire(m, 1'b0);
                fire(m, 1'b0);
                fire(m, 1'b1);
                rd(ierr_pkg::OFS_STS);
                rd(ierr_pkg::OFS_IRQ_STS);
                wr(ierr_pkg::OFS_STS, m);
                rd(ierr_pkg::OFS_STS);
            end
        end
        // Reporting disabled still records; all sources at once
        wr(ierr_pkg::OFS_CTRL, 32'h0);
        wr(ierr_pkg::OFS_MSK, 32'h0);
        fire(32'h0000_8000, 1'b0);
        rd(ierr_pkg::OFS_STS);
        wr(ierr_pkg::OFS_CTRL, 32'h1);
        fire(32'h0007_FFF7, 1'b0);
        wr(ierr_pkg::OFS_STS, 32'hFFFF_FFFF);
        // Random traffic on bus and sources
        for (int i = 0; i < 400; i++) begin
            r = $urandom;
            s = $urandom;
            d = $urandom;
            cyc(r[1:0] == 2'd1, r[1:0] == 2'd0, ofs[int'(r[4:2]) % 7], d,
                s[18:0] & r[31:13], r[12]);
        end
        repeat (3) rd(ierr_pkg::OFS_STS);
        complete_run();
    end

endmodule : ierr_regs_tb
